/* shared/lpw_pkg.sv */
package lpw_pkg;
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_EXT_A = 16'hFFFA;
    localparam logic [15:0] VEC_EXT_B = 16'hFFE0;
    localparam logic [15:0] VEC_BREAK = 16'hFFFC;
    localparam logic [15:0] VEC_CLKGEN = 16'hFFF8;
    localparam logic [15:0] VEC_DMA = 16'hFFF6;
    localparam logic [15:0] VEC_TIM_CH0 = 16'hFFF4;
    localparam logic [15:0] VEC_TIM_STEP = 16'h0002;
    localparam logic [15:0] VEC_SPI_RX = 16'hFFEA;
    localparam logic [15:0] VEC_SPI_TX = 16'hFFE8;
    localparam logic [15:0] VEC_SCI_TX = 16'hFFE2;
    localparam logic [15:0] VEC_KEYPAD = 16'hFFDE;
    localparam int REC_BITS = 12;
    localparam int REC_FULL = 4096;
    localparam int REC_SHORT = 32;
    localparam int TIM_SRCS = 5;
    localparam int SCI_SRCS = 3;

    typedef enum logic [1:0] {
        LPW_RUN,
        LPW_WAIT,
        LPW_STOP,
        LPW_RECOVER
    } lpw_mode_e;

    // peripheral interrupt requests, already enabled by their own units
    typedef struct packed {
        logic clkgen;
        logic dma;
        logic [TIM_SRCS-1:0] tim;
        logic spi_rx;
        logic spi_tx;
        logic [SCI_SRCS-1:0] async_serial_unit;
    } lpw_periph_irq_s;

    // gates and controls sent to the peripherals
    typedef struct packed {
        logic cpu_clk_en;
        logic bus_clk_en;
        logic dma_run;
        logic sci_run;
        logic spi_run;
        logic tim_run;
        logic spi_reset;
    } lpw_ctrl_s;
endpackage : lpw_pkg

/* src/lpw_wake_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

// Contract
// RL1: dma wait-enable set keeps dma running through wait to completion.
// RL2: wait-enable clear suspends dma in wait; resumes on exit if priority set.
// RL3: stop suspends dma; external interrupt exit resumes it when priority set.
// RL4: reset exit from stop aborts the suspended dma transfer.
// RL5: software finishes dma and clears channel enables, or clears mask, before stop.
// RL6: external interrupt pins stay live; clearing a mask lets that pin wake.
// RL7: keypad stays live in wait and stop; clearing its mask enables waking.
// RL8: enabled low-voltage monitor stays live; its reset ends wait or stop.
// RL9: serial, spi, timer run in wait; their enabled requests end wait.
// RL10: serial unit halts in stop, keeps registers, resumes; in-flight frame invalid.
// RL11: spi halts in stop; interrupt exit resumes, reset exit aborts and resets it.
// RL12: timer halts in stop, keeps counter, resumes after interrupt exit.
// RL13: reset in wait restarts cpu clock and fetches the reset vector.
// RL14: falling edge on interrupt pins wakes; pin a, pin b, break have vectors.
// RL15: clock-generator and dma wait wakes use their own vectors.
// RL16: timer wakes vector channel 0 highest down to overflow, two bytes apart.
// RL17: spi rx/tx separate vectors; serial tx, rx, error consecutive upward.
// RL18: only reset, pins, keypad, low-voltage reset or break end stop.
// RL19: stop exit holds system clocks off 4096 crystal cycles via 12-bit counter.
// RL20: short-recovery select shortens the stop recovery to 32 crystal cycles.
// RL21: crystal systems keep short-recovery select cleared for full stabilisation.
// RL22: wait clears mask, stops cpu clock; stop halts bus too; reset sets mask.
// RL23: simultaneous reset and interrupt wake is treated as a reset exit.
module lpw_wake_ctrl
    import lpw_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic crystal_clock,
    input wire logic wait_op,
    input wire logic stop_op,
    input wire logic dma_wait_enable,
    input wire logic dma_priority,
    input wire logic dma_busy,
    input wire logic ext_reset_n,
    input wire logic watchdog_monitor,
    input wire logic low_voltage_monitor,
    input wire logic lvm_reset_enable,
    input wire logic ext_int_pin_a,
    input wire logic ext_int_pin_b,
    input wire logic ext_int1_mask,
    input wire logic ext_int2_mask,
    input wire logic keypad_unit,
    input wire logic keypad_int_mask,
    input wire logic break_irq,
    input wire logic short_recovery_select,
    input wire lpw_periph_irq_s periph_irq,
    output lpw_ctrl_s ctrl,
    output logic [1:0] mode,
    output logic irq_mask,
    output logic dma_abort,
    output logic sci_frame_invalid,
    output logic vector_valid,
    output logic [15:0] vector_addr
);

    ////////////////////////////////////////////////////////////////////////////
    // wake sources
    logic pin_a_reg, pin_b_reg, key_reg, xtal_reg;
    logic fall_a, fall_b, fall_k, xtal_tick, rst_evt, rst_stop, int_stop, int_wait;
    logic [15:0] tim_vec;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_a_reg <= 1'b1;
            pin_b_reg <= 1'b1;
            key_reg <= 1'b1;
            xtal_reg <= 1'b0;
        end else begin
            pin_a_reg <= ext_int_pin_a;
            pin_b_reg <= ext_int_pin_b;
            key_reg <= keypad_unit;
            xtal_reg <= crystal_clock;
        end
    end

    always_comb begin
        fall_a = pin_a_reg & ~ext_int_pin_a & ~ext_int1_mask; // [RL6] [RL14]
        fall_b = pin_b_reg & ~ext_int_pin_b & ~ext_int2_mask; // [RL6] [RL14]
        fall_k = key_reg & ~keypad_unit & ~keypad_int_mask; // [RL7]
        xtal_tick = crystal_clock & ~xtal_reg;
        rst_evt = ~ext_reset_n | watchdog_monitor
                | (low_voltage_monitor & lvm_reset_enable); // [RL8] [RL13]
        // watchdog loses its clock in stop, so it cannot end stop
        rst_stop = ~ext_reset_n | (low_voltage_monitor & lvm_reset_enable); // [RL18]
        int_stop = fall_a | fall_b | fall_k | break_irq; // [RL18]
        int_wait = fall_a | fall_b | fall_k | break_irq | periph_irq.clkgen | periph_irq.dma
                 | (|periph_irq.tim) | periph_irq.spi_rx | periph_irq.spi_tx
                 | (|periph_irq.async_serial_unit); // [RL7] [RL9]
        tim_vec = VEC_TIM_CH0; // [RL16]
        for (int i = 1; i < TIM_SRCS; i++) begin
            if (periph_irq.tim[i]) begin
                tim_vec = VEC_TIM_CH0 - 16'(i * VEC_TIM_STEP);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode sequencer
    lpw_mode_e mode_reg, mode_next;
    logic mask_reg, mask_next, susp_reg, susp_next, abort_reg, abort_next;
    logic inval_reg, inval_next, spirst_reg, spirst_next, vv_reg, vv_next;
    logic [15:0] vec_reg, vec_next;
    logic [REC_BITS-1:0] rec_reg, rec_next;
    logic rec_rst_reg, rec_rst_next;

    function automatic logic [15:0] wait_vector(input lpw_periph_irq_s p, input logic [15:0] tv,
                                                input logic a, input logic b, input logic k,
                                                input logic brk);
        logic [15:0] v;
        v = VEC_SCI_TX;
        if (p.async_serial_unit[2]) v = VEC_SCI_TX + 16'(2 * VEC_TIM_STEP); // [RL17]
        else if (p.async_serial_unit[1]) v = VEC_SCI_TX + VEC_TIM_STEP;
        if (p.spi_tx) v = VEC_SPI_TX; // [RL17]
        if (p.spi_rx) v = VEC_SPI_RX;
        if (|p.tim) v = tv;
        if (p.dma) v = VEC_DMA; // [RL15]
        if (p.clkgen) v = VEC_CLKGEN; // [RL15]
        if (k) v = VEC_KEYPAD; // [RL7]
        if (brk) v = VEC_BREAK; // [RL14]
        if (b) v = VEC_EXT_B; // [RL14]
        if (a) v = VEC_EXT_A; // [RL14]
        return v;
    endfunction : wait_vector

    always_comb begin
        mode_next = mode_reg;
        mask_next = mask_reg;
        susp_next = susp_reg;
        abort_next = 1'b0;
        inval_next = 1'b0;
        spirst_next = 1'b0;
        vv_next = 1'b0;
        vec_next = vec_reg;
        rec_next = rec_reg;
        rec_rst_next = rec_rst_reg;
        case (mode_reg)
            LPW_RUN: begin
                if (rst_evt) begin
                    mask_next = 1'b1;
                end else if (stop_op) begin
                    mode_next = LPW_STOP;
                    mask_next = 1'b0; // [RL22]
                    susp_next = dma_busy; // [RL3]
                    inval_next = 1'b1; // [RL10]
                end else if (wait_op) begin
                    mode_next = LPW_WAIT;
                    mask_next = 1'b0; // [RL22]
                    susp_next = dma_busy & ~dma_wait_enable; // [RL1] [RL2]
                end
            end
            LPW_WAIT: begin
                if (rst_evt) begin // [RL23]
                    mode_next = LPW_RUN;
                    mask_next = 1'b1; // [RL22]
                    abort_next = susp_reg;
                    susp_next = 1'b0;
                    vv_next = 1'b1;
                    vec_next = VEC_RESET; // [RL13]
                end else if (int_wait) begin
                    mode_next = LPW_RUN;
                    abort_next = susp_reg & ~dma_priority; // [RL2]
                    susp_next = 1'b0;
                    vv_next = 1'b1;
                    vec_next = wait_vector(periph_irq, tim_vec, fall_a, fall_b, fall_k, break_irq);
                end
            end
            LPW_STOP: begin
                if (rst_stop | int_stop) begin // [RL18] [RL23]
                    mode_next = LPW_RECOVER;
                    rec_rst_next = rst_stop;
                    rec_next = short_recovery_select
                        ? REC_BITS'(REC_SHORT - 1) : REC_BITS'(REC_FULL - 1); // [RL19] [RL20]
                    if (rst_stop) begin
                        vec_next = VEC_RESET;
                    end else if (fall_a) begin
                        vec_next = VEC_EXT_A;
                    end else if (fall_b) begin
                        vec_next = VEC_EXT_B;
                    end else if (fall_k) begin
                        vec_next = VEC_KEYPAD;
                    end else begin
                        vec_next = VEC_BREAK; // [RL14]
                    end
                end
            end
            LPW_RECOVER: begin
                if (xtal_tick) begin
                    if (rec_reg == '0) begin // [RL19]
                        mode_next = LPW_RUN;
                        vv_next = 1'b1;
                        susp_next = 1'b0;
                        if (rec_rst_reg | rst_stop) begin
                            mask_next = 1'b1; // [RL22]
                            abort_next = susp_reg; // [RL4]
                            spirst_next = 1'b1; // [RL11]
                        end else begin
                            abort_next = susp_reg & ~dma_priority; // [RL3]
                        end
                    end else begin
                        rec_next = rec_reg - 1'b1;
                    end
                end
                if (rst_stop) begin // [RL23]
                    rec_rst_next = 1'b1;
                    vec_next = VEC_RESET;
                end
            end
            default: mode_next = LPW_RUN;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_reg <= LPW_RUN;
            mask_reg <= 1'b1;
            susp_reg <= 1'b0;
            abort_reg <= 1'b0;
            inval_reg <= 1'b0;
            spirst_reg <= 1'b0;
            vv_reg <= 1'b0;
            vec_reg <= VEC_RESET;
            rec_reg <= '0;
            rec_rst_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            mask_reg <= mask_next;
            susp_reg <= susp_next;
            abort_reg <= abort_next;
            inval_reg <= inval_next;
            spirst_reg <= spirst_next;
            vv_reg <= vv_next;
            vec_reg <= vec_next;
            rec_reg <= rec_next;
            rec_rst_reg <= rec_rst_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered gates; keypad and pins need no clock so stay live [RL6] [RL7]
    lpw_ctrl_s ctrl_reg, ctrl_next;

    always_comb begin
        ctrl_next.cpu_clk_en = (mode_next == LPW_RUN); // [RL22]
        ctrl_next.bus_clk_en = (mode_next == LPW_RUN) || (mode_next == LPW_WAIT); // [RL22]
        ctrl_next.dma_run = ctrl_next.bus_clk_en & ~susp_next; // [RL1] [RL2] [RL3]
        ctrl_next.sci_run = ctrl_next.bus_clk_en; // [RL9] [RL10]
        ctrl_next.spi_run = ctrl_next.bus_clk_en; // [RL9] [RL11]
        ctrl_next.tim_run = ctrl_next.bus_clk_en; // [RL9] [RL12]
        ctrl_next.spi_reset = spirst_next; // [RL11]
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= '{cpu_clk_en: 1'b1, bus_clk_en: 1'b1, dma_run: 1'b1,
                          sci_run: 1'b1, spi_run: 1'b1, tim_run: 1'b1, spi_reset: 1'b0};
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    always_comb begin
        ctrl = ctrl_reg;
        mode = mode_reg;
        irq_mask = mask_reg;
        dma_abort = abort_reg;
        sci_frame_invalid = inval_reg;
        vector_valid = vv_reg;
        vector_addr = vec_reg;
    end

endmodule : lpw_wake_ctrl

`default_nettype wire

/* verification/lpw_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lpw_far_model
    import lpw_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [1:0] mode,
    input wire lpw_ctrl_s ctrl,
    input wire logic dma_abort,
    input wire logic dma_start,
    output logic crystal_clock,
    output logic dma_busy
);
    logic [1:0] xdiv_reg;
    int left_reg;
    // oscillator held low in stop, restarts at zero phase on wake
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            xdiv_reg <= 2'h0;
            left_reg <= 0;
        end else begin
            xdiv_reg <= (mode == LPW_STOP) ? 2'h0 : xdiv_reg + 2'h1;
            if (dma_abort) begin
                left_reg <= 0;
            end else if (dma_start) begin
                left_reg <= 40;
            end else if (left_reg > 0 && ctrl.dma_run) begin
                left_reg <= left_reg - 1;
            end
        end
    end
    assign crystal_clock = xdiv_reg[1];
    assign dma_busy = left_reg > 0;
endmodule : lpw_far_model
`default_nettype wire

/* verification/lpw_wake_ctrl_props.sv */
`timescale 1ns/1ps
`default_nettype none
module lpw_wake_ctrl_props
    import lpw_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic wait_op,
    input wire logic stop_op,
    input wire logic dma_wait_enable,
    input wire logic ext_reset_n,
    input wire logic watchdog_monitor,
    input wire logic low_voltage_monitor,
    input wire logic lvm_reset_enable,
    input wire logic ext_int_pin_a,
    input wire logic ext_int1_mask,
    input wire logic break_irq,
    input wire lpw_ctrl_s ctrl,
    input wire logic [1:0] mode,
    input wire logic irq_mask,
    input wire logic sci_frame_invalid,
    input wire logic vector_valid,
    input wire logic [15:0] vector_addr
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic lvr;
    logic rst_ev;
    assign lvr = low_voltage_monitor && lvm_reset_enable;
    // watchdog wakes wait only, so the stop check leaves it out
    assign rst_ev = !ext_reset_n || watchdog_monitor || lvr;
    wait_entry_a: assert property (mode == 2'h0 && wait_op && !stop_op && !rst_ev |=>
        mode == 2'h1 && !ctrl.cpu_clk_en && ctrl.bus_clk_en && !irq_mask) else $error("wait in");
    stop_entry_a: assert property (mode == 2'h0 && stop_op && !rst_ev |=>
        mode == 2'h2 && !ctrl.bus_clk_en && !ctrl.dma_run && !ctrl.tim_run && sci_frame_invalid)
        else $error("stop in");
    dma_keep_a: assert property ($rose(mode == 2'h1) && $past(dma_wait_enable) |->
        ctrl.dma_run) else $error("dma halted");
    wait_reset_a: assert property (mode == 2'h1 && rst_ev |=> vector_valid &&
        vector_addr == VEC_RESET && irq_mask && ctrl.cpu_clk_en) else $error("wait reset");
    pin_wake_a: assert property (mode == 2'h2 && $fell(ext_int_pin_a) &&
        !ext_int1_mask && ext_reset_n && !lvr && !break_irq |=>
        mode == 2'h3 && vector_addr == VEC_EXT_A) else $error("pin wake");
    recover_off_a: assert property (mode == 2'h3 |->
        !ctrl.cpu_clk_en && !ctrl.bus_clk_en) else $error("clock on");
    recover_exit_a: assert property ($past(mode) == 2'h3 && mode == 2'h0 |-> vector_valid)
        else $error("no vector");
    run_reset_a: assert property (mode == 2'h0 && rst_ev |=> irq_mask)
        else $error("mask clear");
endmodule : lpw_wake_ctrl_props
bind lpw_wake_ctrl lpw_wake_ctrl_props u_lpw_wake_ctrl_props (.core_clk, .sys_rst, .wait_op,
    .stop_op, .dma_wait_enable, .ext_reset_n, .watchdog_monitor, .low_voltage_monitor,
    .lvm_reset_enable, .ext_int_pin_a, .ext_int1_mask, .break_irq, .ctrl, .mode, .irq_mask,
    .sci_frame_invalid, .vector_valid, .vector_addr);
`default_nettype wire

/* verification/lpw_wake_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module lpw_wake_ctrl_tb
    import lpw_pkg::*;
;
    logic core_clk = 1'b0;
    logic sys_rst, wait_op, stop_op, dma_wait_enable, dma_priority, dma_start, break_irq;
    logic ext_reset_n, watchdog_monitor, low_voltage_monitor, lvm_reset_enable, keypad_unit;
    logic ext_int_pin_a, ext_int_pin_b, ext_int1_mask, ext_int2_mask, keypad_int_mask;
    logic short_recovery_select, crystal_clock, dma_busy, irq_mask, dma_abort, vector_valid;
    logic sci_frame_invalid, ab_seen, sr_seen;
    logic [1:0] mode;
    logic [15:0] vector_addr, ev;
    logic [31:0] r;
    lpw_periph_irq_s periph_irq;
    lpw_ctrl_s ctrl;
    int fails = 0, checks_done = 0, n, ex;
    logic [15:0] wvec [14] = '{16'hFFFA, 16'hFFE0, 16'hFFF8, 16'hFFF6, 16'hFFEC, 16'hFFEE,
        16'hFFF0, 16'hFFF2, 16'hFFF4, 16'hFFEA, 16'hFFE8, 16'hFFE6, 16'hFFE4, 16'hFFE2};
    logic [15:0] svec [6] = '{16'hFFFA, 16'hFFE0, 16'hFFDE, 16'hFFFC, 16'hFFFE, 16'hFFFE};
    always #2 core_clk = ~core_clk;
    lpw_wake_ctrl u_lpw_wake_ctrl (.core_clk, .sys_rst, .crystal_clock, .wait_op, .stop_op,
        .dma_wait_enable, .dma_priority, .dma_busy, .ext_reset_n, .watchdog_monitor,
        .low_voltage_monitor, .lvm_reset_enable, .ext_int_pin_a, .ext_int_pin_b, .ext_int1_mask,
        .ext_int2_mask, .keypad_unit, .keypad_int_mask, .break_irq, .short_recovery_select,
        .periph_irq, .ctrl, .mode, .irq_mask, .dma_abort, .sci_frame_invalid, .vector_valid,
        .vector_addr);
    lpw_far_model u_lpw_far_model (.core_clk, .sys_rst, .mode, .ctrl, .dma_abort, .dma_start,
        .crystal_clock, .dma_busy);
    ////////////////////////////////////////
    // pulses are caught here since they stand one cycle only
    always @(posedge core_clk) begin
        if (dma_abort === 1'b1) ab_seen = 1'b1;
        if (ctrl.spi_reset === 1'b1) sr_seen = 1'b1;
    end
    task automatic step(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask : step
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic wait_vec(input int lim);
        n = 0;
        while (vector_valid !== 1'b1) begin
            if (n == lim) begin
                fails++;
                tally_and_finish();
            end
            step(1);
            n++;
        end
    endtask : wait_vec
    ////////////////////////////////////////
    initial begin
        {sys_rst, ext_reset_n, ext_int_pin_a, ext_int_pin_b, keypad_unit} = 5'h1F;
        {ext_int1_mask, ext_int2_mask, keypad_int_mask} = 3'h7;
        {wait_op, stop_op, dma_wait_enable, dma_priority, dma_start, break_irq} = 6'h0;
        {watchdog_monitor, low_voltage_monitor, lvm_reset_enable, short_recovery_select} = 4'h0;
        {periph_irq, ab_seen, sr_seen} = 14'h0;
        void'($urandom(32'h3FFE79E0));
        step(20);
        sys_rst = 1'b0;
        chk({mode, irq_mask, ctrl, 6'h0}, 16'h3F80);
        chk(vector_addr, 16'hFFFE);
        {ext_int1_mask, ext_int2_mask, keypad_int_mask} = 3'h0;
        for (int i = 0; i < 20; i++) begin
            r = $urandom;
            {dma_wait_enable, dma_priority, dma_start} = {r[1:0], 1'b1};
            step(1);
            {dma_start, wait_op} = 2'h1;
            step(1);
            wait_op = 1'b0;
            chk({13'h0, mode, ctrl.dma_run}, {14'h1, r[1]});
            step(int'(r[5:2]));
            if (i == 0) ext_int_pin_a = 1'b0;
            else if (i == 1) ext_int_pin_b = 1'b0;
            else if (i < 14) periph_irq = 12'h800 >> (i - 2);
            else if (i == 18) keypad_unit = 1'b0;
            else if (i == 19) break_irq = 1'b1;
            else begin
                ext_reset_n = (i == 15 || i == 16);
                watchdog_monitor = (i == 15);
                {low_voltage_monitor, lvm_reset_enable} = {2{i == 16}};
                ext_int_pin_a = (i != 17);
            end
            wait_vec(100);
            ev = (i < 14) ? wvec[i] : (i == 18) ? 16'hFFDE : (i == 19) ? 16'hFFFC : 16'hFFFE;
            chk(vector_addr, ev);
            chk({15'h0, irq_mask}, {15'h0, i > 13 && i < 18});
            step(1);
            {ext_int_pin_a, ext_int_pin_b, ext_reset_n, periph_irq} = {3'h7, 12'h0};
            {keypad_unit, break_irq} = 2'h2;
            {watchdog_monitor, low_voltage_monitor, lvm_reset_enable} = 3'h0;
            step(2);
            if (i < 14 || i > 17) chk({15'h0, dma_busy}, {15'h0, r[0] | r[1]});
            step(45);
        end
        for (int k = 0; k < 6; k++) begin
            short_recovery_select = (k != 0);
            ex = (k != 0 ? 32 : 4096) * 4;
            {dma_wait_enable, dma_priority, dma_start} = 3'h3;
            step(1);
            // dma left live on purpose: stop suspends it, pin, keypad or break wakes resume it, reset wakes abort it
            {dma_start, stop_op, ab_seen, sr_seen} = 4'h4;
            step(1);
            stop_op = 1'b0;
            chk({13'h0, mode, sci_frame_invalid}, 16'h5);
            {periph_irq, watchdog_monitor} = 13'h1FFF;
            step(12);
            chk({14'h0, mode}, 16'h2);
            {periph_irq, watchdog_monitor} = 13'h0;
            {ext_int_pin_a, ext_int_pin_b, keypad_unit} = {k != 0, k != 1, k != 2};
            {break_irq, ext_reset_n} = {k == 3, k != 4};
            {low_voltage_monitor, lvm_reset_enable} = {2{k == 5}};
            step(2);
            {ext_int_pin_a, ext_int_pin_b, keypad_unit, ext_reset_n} = 4'hF;
            {break_irq, low_voltage_monitor, lvm_reset_enable} = 3'h0;
            wait_vec(20000);
            chk({15'h0, n > ex - 9 && n < ex + 6}, 16'h1);
            chk(vector_addr, svec[k]);
            if (k > 3) chk({15'h0, irq_mask}, 16'h1);
            step(2);
            chk({6'h0, ctrl, dma_busy, ab_seen, sr_seen},
                {13'h07E, k < 4, k > 3, k > 3});
            step(45);
        end
        tally_and_finish();
    end
endmodule : lpw_wake_ctrl_tb
`default_nettype wire
